// [hdl/dcl_pkg.sv]
// constants, phase encoding and carrier types for the ddr chip-to-chip link
// assumes one transmitter and one receiver built from the same constants
package dcl_pkg;

  // word and link widths
  localparam int USER_W   = 16;
  localparam int LINK_W   = 4;
  localparam int PAR_W    = 2 * LINK_W;
  localparam int FUNNEL   = USER_W / PAR_W;
  localparam int FUN_W    = (FUNNEL > 1) ? $clog2(FUNNEL) : 1;

  // buffer depths
  localparam int TX_DEPTH = 16;
  localparam int TX_AW    = $clog2(TX_DEPTH);
  localparam int RX_DEPTH = 64;
  localparam int RX_AW    = $clog2(RX_DEPTH);
  localparam int PF_DEPTH = 4;
  localparam int PF_AW    = 2;
  localparam int PF_W     = PAR_W + 1;
  localparam int LOCK_W   = 16;

  // counts at the widths they are compared against
  localparam logic [TX_AW:0]    TX_DEPTH_C      = (TX_AW+1)'('h10);
  localparam logic [RX_AW:0]    RX_DEPTH_C      = (RX_AW+1)'('h40);
  localparam logic [RX_AW:0]    NEAR_FULL_SPACE = (RX_AW+1)'('h20);
  localparam logic [PF_AW:0]    PF_START_LAG    = (PF_AW+1)'('h2);
  localparam logic [LOCK_W-1:0] LOCK_CYCLES_DEF = 16'h0040;

  // half periods of the link clock
  typedef enum logic {
    DCL_PH_FIRST  = 1'b0,
    DCL_PH_SECOND = 1'b1
  } dcl_phase_t;

  // parcel lines as they cross the board
  typedef struct packed {
    logic              flag;
    logic [LINK_W-1:0] data;
  } dcl_parcel_t;

  // transmit pins: forwarded clock plus parcel lines
  typedef struct packed {
    logic        forwarded_link_clock;
    dcl_parcel_t parcel;
  } dcl_link_t;

  // user write request
  typedef struct packed {
    logic              wr;
    logic [USER_W-1:0] data;
  } dcl_wr_t;

endpackage

// [hdl/dcl_link.sv]
// ddr chip-to-chip link: transmit core and receive core in one block
// clk is the user clock; the link clock is made from it by halving.
// rx_clk is the receiver's recovered clock at the parcel rate, aligned so
// its rising edge falls mid-parcel; the bench drives it separately.
`timescale 1ns/100ps

module dcl_link #(
  parameter logic [dcl_pkg::LOCK_W-1:0] LOCK_CYCLES = dcl_pkg::LOCK_CYCLES_DEF
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          rx_clk,
  input  wire dcl_pkg::dcl_wr_t              tx_wr,
  output logic                               tx_full_q,
  output dcl_pkg::dcl_link_t                 tx_link_q,
  output logic                               far_side_reset_q,
  input  wire logic                          tx_near_full_in,
  input  wire dcl_pkg::dcl_parcel_t          rx_parcel_in,
  input  wire logic                          rx_far_reset_in,
  output logic                               rx_near_full_q,
  input  wire logic                          rx_rd,
  output logic [dcl_pkg::USER_W-1:0]         rx_data_q,
  output logic                               rx_empty_q
);

  // widest slice of 4, 2 or 1 bits that divides the link evenly
  function automatic int slice_w(input int w);
    if (w % 4 == 0) begin
      return 4;
    end else if (w % 2 == 0) begin
      return 2;
    end
    return 1;
  endfunction

  localparam int SW = slice_w(dcl_pkg::LINK_W);
  localparam int NS = dcl_pkg::LINK_W / SW;

  // pick the lower or upper half of every slice
  function automatic logic [dcl_pkg::LINK_W-1:0] ser_half(input logic [dcl_pkg::PAR_W-1:0] w,
                                                            input logic upper);
    logic [dcl_pkg::LINK_W-1:0] o;
    o = '0;
    for (int i = 0; i < NS; i++) begin
      o[i*SW +: SW] = upper ? w[2*SW*i+SW +: SW] : w[2*SW*i +: SW];
    end
    return o;
  endfunction

  // rejoin both halves of every slice
  function automatic logic [dcl_pkg::PAR_W-1:0] deser(input logic [dcl_pkg::LINK_W-1:0] lo,
                                                        input logic [dcl_pkg::LINK_W-1:0] hi);
    logic [dcl_pkg::PAR_W-1:0] w;
    w = '0;
    for (int i = 0; i < NS; i++) begin
      w[2*SW*i +: SW]    = lo[i*SW +: SW];
      w[2*SW*i+SW +: SW] = hi[i*SW +: SW];
    end
    return w;
  endfunction

  // gray code keeps the pointer crossing to one changing bit
  function automatic logic [dcl_pkg::PF_AW:0] bin2gray(input logic [dcl_pkg::PF_AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // back to binary for the occupancy difference
  function automatic logic [dcl_pkg::PF_AW:0] gray2bin(input logic [dcl_pkg::PF_AW:0] g);
    logic [dcl_pkg::PF_AW:0] b;
    b = '0;
    for (int i = dcl_pkg::PF_AW; i >= 0; i--) begin
      b[i] = (i == dcl_pkg::PF_AW) ? g[i] : (b[i+1] ^ g[i]);
    end
    return b;
  endfunction

  // clk-domain fields, in order:
  //   phase     which half of the link period the next edge leaves
  //   link      registered pins: forwarded clock, flag, data
  //   ser       link word being shifted out this period
  //   txm       transmit fifo storage, user width
  //   twp, trp  transmit write and read pointers, one extra wrap bit
  //   tsub      which link word of the current user word goes next
  //   tfull     registered full flag, also held during lock wait
  //   lock_cnt  counts clk edges while waiting for lock
  //   locked    set once the count expires; cleared only by rst
  //   far_rst   reset handed to the far side until locked
  //   nf1, nf2  near-full synchroniser
  //   fr1, fr2  far reset synchroniser for the receive back end
  //   wg1, wg2  gray write pointer of the phase fifo, synchronised
  //   prp       phase fifo read pointer, binary
  //   pstart    reading of the phase fifo has begun
  //   rxm       receive fifo storage, user width
  //   rwp, rrp  receive write and read pointers, one extra wrap bit
  //   rsub      which half of the current receive word fills next
  //   rdat      read data, held until the next accepted read
  //   rempty    registered empty flag
  //   nfull     near-full, also high until the phase fifo starts
  // state of the clk domain: transmitter plus receive back end
  typedef struct packed {
    dcl_pkg::dcl_phase_t                                   phase;
    dcl_pkg::dcl_link_t                                    link;
    logic [dcl_pkg::PAR_W-1:0]                             ser;
    logic [dcl_pkg::TX_DEPTH-1:0][dcl_pkg::USER_W-1:0]     txm;
    logic [dcl_pkg::TX_AW:0]                               twp;
    logic [dcl_pkg::TX_AW:0]                               trp;
    logic [dcl_pkg::FUN_W-1:0]                             tsub;
    logic                                                  tfull;
    logic [dcl_pkg::LOCK_W-1:0]                            lock_cnt;
    logic                                                  locked;
    logic                                                  far_rst;
    logic                                                  nf1;
    logic                                                  nf2;
    logic                                                  fr1;
    logic                                                  fr2;
    logic [dcl_pkg::PF_AW:0]                               wg1;
    logic [dcl_pkg::PF_AW:0]                               wg2;
    logic [dcl_pkg::PF_AW:0]                               prp;
    logic                                                  pstart;
    logic [dcl_pkg::RX_DEPTH-1:0][dcl_pkg::USER_W-1:0]     rxm;
    logic [dcl_pkg::RX_AW:0]                               rwp;
    logic [dcl_pkg::RX_AW:0]                               rrp;
    logic [dcl_pkg::FUN_W-1:0]                             rsub;
    logic [dcl_pkg::USER_W-1:0]                            rdat;
    logic                                                  rempty;
    logic                                                  nfull;
  } dcl_core_t;

  // rx_clk-domain fields, in order:
  //   fr1, fr2  far reset synchroniser in this domain
  //   cap       single capture stage of the parcel lines
  //   ph        phase that the next captured parcel belongs to
  //   lo        first parcel of the pair, waiting for its partner
  //   f0        flag of the first parcel, stored as the word's valid bit
  //   wp        phase fifo write pointer, binary with wrap bit
  //   wg        the same pointer in gray code for the crossing
  //   pm        phase fifo storage, flag bit on top
  // state of the rx_clk domain: capture, deserializer, phase fifo writer
  typedef struct packed {
    logic                                                  fr1;
    logic                                                  fr2;
    dcl_pkg::dcl_parcel_t                                  cap;
    dcl_pkg::dcl_phase_t                                   ph;
    logic [dcl_pkg::LINK_W-1:0]                            lo;
    logic                                                  f0;
    logic [dcl_pkg::PF_AW:0]                               wp;
    logic [dcl_pkg::PF_AW:0]                               wg;
    logic [dcl_pkg::PF_DEPTH-1:0][dcl_pkg::PF_W-1:0]       pm;
  } dcl_rxl_t;

  dcl_core_t q;
  dcl_core_t d;
  dcl_rxl_t  qr;
  dcl_rxl_t  dr;

  // receive front end, runs on the recovered link clock
  always_comb begin
    dr = qr;
    // far reset is asynchronous to this domain
    dr.fr1 = rx_far_reset_in;
    dr.fr2 = qr.fr1;
    // parcels are source-synchronous, one capture stage only
    dr.cap = rx_parcel_in;
    if (qr.ph == dcl_pkg::DCL_PH_FIRST) begin
      dr.lo = qr.cap.data;
      dr.f0 = qr.cap.flag;
      dr.ph = dcl_pkg::DCL_PH_SECOND;
    end else if (qr.cap.flag) begin
      // flag never rises in the second phase, so this sample opens a pair
      dr.lo = qr.cap.data;
      dr.f0 = 1'b1;
      dr.ph = dcl_pkg::DCL_PH_SECOND;
    end else begin
      // pair complete: write phase fifo every period, valid or idle
      dr.pm[qr.wp[dcl_pkg::PF_AW-1:0]] = {qr.f0, deser(qr.lo, qr.cap.data)};
      dr.wp = qr.wp + 1'b1;
      dr.wg = bin2gray(dr.wp);
      dr.ph = dcl_pkg::DCL_PH_FIRST;
    end
    // only the propagated reset reaches the receiver
    if (qr.fr2) begin
      dr.ph = dcl_pkg::DCL_PH_FIRST;
      dr.f0 = 1'b0;
      dr.wp = '0;
      dr.wg = '0;
    end
  end

  // rx_clk domain registers
  // no reset here: the far reset works through the next-state logic
  always_ff @(posedge rx_clk) begin
    qr <= dr;
  end

  // transmitter and receive back end, on clk
  always_comb begin
    logic                            send;
    logic [dcl_pkg::PF_AW:0]         occ;
    logic [dcl_pkg::PF_W-1:0]        pword;
    logic [dcl_pkg::RX_AW:0]         used;
    logic [dcl_pkg::RX_AW:0]         rfree;
    send  = 1'b0;
    occ   = '0;
    pword = '0;
    used  = '0;
    rfree = '0;
    d     = q;

    // two-flop synchronisers for the asynchronous side signals
    d.nf1 = tx_near_full_in;
    d.nf2 = q.nf1;
    d.fr1 = rx_far_reset_in;
    d.fr2 = q.fr1;
    d.wg1 = qr.wg;
    d.wg2 = q.wg1;

    // stand-in for the link clock generator lock
    // the count stands in for a clock generator; shorten it only in simulation
    if (!q.locked) begin
      d.lock_cnt = q.lock_cnt + 1'b1;
      if (q.lock_cnt == LOCK_CYCLES - 1'b1) begin
        d.locked = 1'b1;
      end
    end
    d.far_rst = !d.locked;

    // user write port, wide side of the funnel
    if (tx_wr.wr && !q.tfull) begin
      d.txm[q.twp[dcl_pkg::TX_AW-1:0]] = tx_wr.data;
      d.twp = q.twp + 1'b1;
    end

    // link clock is clk halved: high in the first phase
    if (q.phase == dcl_pkg::DCL_PH_SECOND) begin
      // word decision made once per link period, before the first phase
      send = q.locked && !q.nf2 && (q.twp != q.trp);
      d.phase = dcl_pkg::DCL_PH_FIRST;
      d.link.forwarded_link_clock = 1'b1;
      d.link.parcel.flag = send;
      if (send) begin
        d.ser = q.txm[q.trp[dcl_pkg::TX_AW-1:0]][q.tsub*dcl_pkg::PAR_W +: dcl_pkg::PAR_W];
        d.tsub = q.tsub + 1'b1;
        if (q.tsub == dcl_pkg::FUN_W'(dcl_pkg::FUNNEL - 1)) begin
          d.tsub = '0;
          d.trp  = q.trp + 1'b1;
        end
      end
      d.link.parcel.data = ser_half(d.ser, 1'b0);
    end else begin
      d.phase = dcl_pkg::DCL_PH_SECOND;
      d.link.forwarded_link_clock = 1'b0;
      d.link.parcel.flag = 1'b0;
      d.link.parcel.data = ser_half(q.ser, 1'b1);
    end
    // flag and data leave through the same output flops
    d.tfull = ((d.twp - d.trp) == dcl_pkg::TX_DEPTH_C) || !d.locked;

    // limitation: the read side trusts the gray pointer alone; data words are
    // read straight out of the rx_clk registers, which is safe only because a
    // word is written at least two clk edges before its pointer is seen here
    // trade-off: received words that meet a completely full receive fifo are
    // dropped rather than stalling the crossing, which must keep running;
    // the near-full margin of 32 entries keeps this from happening in use
    // phase fifo read side; start lag hides the unknown write phase
    occ = gray2bin(q.wg2) - q.prp;
    if (!q.pstart && occ >= dcl_pkg::PF_START_LAG) begin
      d.pstart = 1'b1;
    end
    if (q.pstart && occ != '0) begin
      pword = qr.pm[q.prp[dcl_pkg::PF_AW-1:0]];
      d.prp = q.prp + 1'b1;
      // idle words are dropped whatever the bus held
      if (pword[dcl_pkg::PF_W-1] && (q.rwp - q.rrp) != dcl_pkg::RX_DEPTH_C) begin
        d.rxm[q.rwp[dcl_pkg::RX_AW-1:0]][q.rsub*dcl_pkg::PAR_W +: dcl_pkg::PAR_W] =
          pword[dcl_pkg::PAR_W-1:0];
        d.rsub = q.rsub + 1'b1;
        if (q.rsub == dcl_pkg::FUN_W'(dcl_pkg::FUNNEL - 1)) begin
          d.rsub = '0;
          d.rwp  = q.rwp + 1'b1;
        end
      end
    end

    // user read port, data held until the next read
    if (rx_rd && !q.rempty) begin
      d.rdat = q.rxm[q.rrp[dcl_pkg::RX_AW-1:0]];
      d.rrp  = q.rrp + 1'b1;
    end
    d.rempty = (d.rwp == d.rrp);

    // a half-filled slot already counts as used; slack covers link latency
    used  = d.rwp - d.rrp + {{dcl_pkg::RX_AW{1'b0}}, (d.rsub != '0)};
    rfree = dcl_pkg::RX_DEPTH_C - used;
    d.nfull = !d.pstart || (rfree <= dcl_pkg::NEAR_FULL_SPACE);

    // master reset: transmitter only, plus the near-full and far reset synchronisers
    if (rst) begin
      d.phase    = dcl_pkg::DCL_PH_FIRST;
      d.link     = '0;
      d.ser      = '0;
      d.twp      = '0;
      d.trp      = '0;
      d.tsub     = '0;
      d.tfull    = 1'b1;
      d.lock_cnt = '0;
      d.locked   = 1'b0;
      d.far_rst  = 1'b1;
      d.nf1      = 1'b1;
      d.nf2      = 1'b1;
      d.fr1      = 1'b1;
      d.fr2      = 1'b1;
    end

    // receive back end follows the propagated reset only
    if (q.fr2) begin
      d.prp    = '0;
      d.pstart = 1'b0;
      d.rwp    = '0;
      d.rrp    = '0;
      d.rsub   = '0;
      d.rdat   = '0;
      d.rempty = 1'b1;
      d.nfull  = 1'b1;
    end
  end

  // clk domain registers
  always_ff @(posedge clk) begin
    q <= d;
  end

  // outputs straight from flops
  assign tx_full_q        = q.tfull;
  assign tx_link_q        = q.link;
  assign far_side_reset_q = q.far_rst;
  assign rx_near_full_q   = q.nfull;
  assign rx_data_q        = q.rdat;
  assign rx_empty_q       = q.rempty;

endmodule // dcl_link

// [tb/dcl_link_sva.sv]
// checker for the link block, watching its ports only
// assumes rst is synchronous to clk and the lock count comes through the bind
`timescale 1ns/100ps

module dcl_link_chk #(
  parameter logic [dcl_pkg::LOCK_W-1:0] LOCK_CYCLES = dcl_pkg::LOCK_CYCLES_DEF
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  rx_clk,
  input wire dcl_pkg::dcl_wr_t      tx_wr,
  input wire logic                  tx_full_q,
  input wire dcl_pkg::dcl_link_t    tx_link_q,
  input wire logic                  far_side_reset_q,
  input wire logic                  tx_near_full_in,
  input wire dcl_pkg::dcl_parcel_t  rx_parcel_in,
  input wire logic                  rx_far_reset_in,
  input wire logic                  rx_near_full_q,
  input wire logic                  rx_rd,
  input wire logic [15:0]           rx_data_q,
  input wire logic                  rx_empty_q
);
  logic [15:0] cnt_q; // edges since reset release

  // saturating count so the lock window can be judged late in the run too
  always_ff @(posedge clk) begin
    if (rst) cnt_q <= 16'h0000;
    else if (cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_clk_half;
    disable iff (rst || far_side_reset_q) !$past(far_side_reset_q) |-> tx_link_q.forwarded_link_clock != $past(tx_link_q.forwarded_link_clock);
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("link clock not halving");
  property p_flag_phase; tx_link_q.parcel.flag |-> tx_link_q.forwarded_link_clock ##1 !tx_link_q.parcel.flag; endproperty
  a_flag_phase: assert property (p_flag_phase) else $error("flag outside first phase");
  property p_idle_lock; far_side_reset_q |-> !tx_link_q.parcel.flag; endproperty
  a_idle_lock: assert property (p_idle_lock) else $error("parcel sent before lock");
  property p_reset_prop; disable iff (1'b0) rst |=> far_side_reset_q && !tx_link_q.parcel.flag; endproperty
  a_reset_prop: assert property (p_reset_prop) else $error("master reset not passed on");
  property p_stall; tx_near_full_in [*5] |-> !tx_link_q.parcel.flag; endproperty
  a_stall: assert property (p_stall) else $error("parcel sent while peer near full");
  property p_lock_hold; cnt_q < LOCK_CYCLES |-> far_side_reset_q; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("far reset released early");
  property p_lock_end; cnt_q >= LOCK_CYCLES + 16'h0003 |-> !far_side_reset_q; endproperty
  a_lock_end: assert property (p_lock_end) else $error("far reset held too long");
  property p_full_lock; far_side_reset_q |-> tx_full_q; endproperty
  a_full_lock: assert property (p_full_lock) else $error("write port open before lock");
  property p_rx_ready; rx_far_reset_in [*3] |-> rx_near_full_q && rx_empty_q; endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("receiver ready during reset");
  property p_rd_hold; disable iff (rst || rx_far_reset_in) !(rx_rd && !rx_empty_q) |=> $stable(rx_data_q); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");

  // main scenarios reached
  c_send: cover property (tx_link_q.parcel.flag);
  c_read: cover property (rx_rd && !rx_empty_q);
  c_near: cover property ($rose(rx_near_full_q));
  c_refuse: cover property (tx_wr.wr && tx_full_q);
endmodule // dcl_link_chk

bind dcl_link dcl_link_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .rx_clk(rx_clk), .tx_wr(tx_wr), .tx_full_q(tx_full_q), .tx_link_q(tx_link_q),
  .far_side_reset_q(far_side_reset_q), .tx_near_full_in(tx_near_full_in), .rx_parcel_in(rx_parcel_in),
  .rx_far_reset_in(rx_far_reset_in), .rx_near_full_q(rx_near_full_q), .rx_rd(rx_rd), .rx_data_q(rx_data_q),
  .rx_empty_q(rx_empty_q));

// [tb/dcl_peer.sv]
// peer chip model: receiver of our link output, transmitter into our link input
// assumes the bench makes rx_clk free running; parcels land mid-period on its rise
`timescale 1ns/100ps

module dcl_peer (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 rx_clk,
  input  wire logic                 stall,
  input  wire dcl_pkg::dcl_link_t   link,
  output logic                      near_full,
  output dcl_pkg::dcl_parcel_t      parcel,
  output logic                      far_reset,
  output logic                      got_v,
  output logic [15:0]               got_w
);
  dcl_pkg::dcl_parcel_t pq[$]; // parcels waiting to go out
  logic [15:0]          sh_q;  // nibble shift register
  logic [1:0]           n_q;   // nibbles of the current word
  logic [2:0]           rc_q;  // rx_clk edges since reset

  // not ready while in reset or told to stall
  assign near_full = stall | rst;
  // far reset stretched over several link edges so the slow domain sees it
  assign far_reset = (rc_q < 3'h4);
  always @(posedge rx_clk or posedge rst) begin
    if (rst) rc_q <= 3'h0;
    else if (rc_q < 3'h4) rc_q <= rc_q + 3'h1;
  end

  // a word is two flagged pairs, low nibble first, flag low on second parcels
  task send_word(input logic [15:0] w);
    pq.push_back({1'b1, w[3:0]});
    pq.push_back({1'b0, w[7:4]});
    pq.push_back({1'b1, w[11:8]});
    pq.push_back({1'b0, w[15:12]});
  endtask

  // launch on the falling edge; idle data toggles so stale levels never pass
  initial parcel = '0;
  always @(negedge rx_clk) begin
    if (pq.size() > 0) parcel <= pq.pop_front();
    else parcel <= {1'b0, ~parcel.data};
  end

  // gather four nibbles; the parcel after a flag belongs to it, idle ones ignored
  always @(posedge clk) begin
    got_v <= 1'b0;
    if (rst) n_q <= 2'h0;
    else if (link.parcel.flag || n_q[0]) begin
      sh_q <= {link.parcel.data, sh_q[15:4]};
      n_q <= n_q + 2'h1;
      if (n_q == 2'h3) begin
        got_v <= 1'b1;
        got_w <= {link.parcel.data, sh_q[15:4]};
      end
    end
  end
endmodule // dcl_peer

// [tb/dcl_link_bench.sv]
// self-checking bench for the link block against a peer chip model
// assumes 16-bit user words over a 4-bit link, lock count shortened to 4
`timescale 1ns/100ps
`define CHK(nm, ex, ac) \
  begin \
    tests_run++; \
    if ((ac) !== (ex)) begin \
      fail_count++; \
      $display("wrong value %s exp %h got %h", nm, ex, ac); \
    end \
  end

module dcl_link_bench;
  logic                 clk, rst, rx_clk, stall, rx_rd, rd_pend;
  logic                 tx_full, far_rst_out, near_in, far_rst_in, rx_nf, rx_empty, got_v;
  logic [15:0]          rx_data, got_w, ew;
  logic [15:0]          exp_tx[$], exp_rx[$];
  logic [31:0]          seed = 32'hD831;
  dcl_pkg::dcl_wr_t     tx_wr;
  dcl_pkg::dcl_link_t   tx_link;
  dcl_pkg::dcl_parcel_t parcel;
  int                   fail_count, tests_run, i;

  dcl_link #(.LOCK_CYCLES(16'h0004)) uut (
    .clk(clk), .rst(rst), .rx_clk(rx_clk), .tx_wr(tx_wr), .tx_full_q(tx_full), .tx_link_q(tx_link),
    .far_side_reset_q(far_rst_out), .tx_near_full_in(near_in), .rx_parcel_in(parcel),
    .rx_far_reset_in(far_rst_in), .rx_near_full_q(rx_nf), .rx_rd(rx_rd), .rx_data_q(rx_data),
    .rx_empty_q(rx_empty));
  dcl_peer peer (
    .clk(clk), .rst(rst), .rx_clk(rx_clk), .stall(stall), .link(tx_link), .near_full(near_in),
    .parcel(parcel), .far_reset(far_rst_in), .got_v(got_v), .got_w(got_w));

  // user clock and an unrelated link clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rx_clk = 1'b0;
    #7.3;
    forever #62.5 rx_clk = ~rx_clk;
  end

  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction

  task complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task tmo(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      complete_run();
    end
  endtask

  // request held from one falling edge to the next, entered only when not full
  task wr_word(input logic [15:0] w);
    for (i = 0; i < 200 && tx_full !== 1'b0; i++) begin
      tx_wr.wr = 1'b0;
      @(negedge clk);
    end
    tmo(i, 200);
    tx_wr = {1'b1, w};
    exp_tx.push_back(w);
    @(negedge clk);
  endtask

  task rd_word();
    for (i = 0; i < 200 && rx_empty !== 1'b0; i++) begin
      rx_rd = 1'b0;
      @(negedge clk);
    end
    tmo(i, 200);
    rx_rd = 1'b1;
    @(negedge clk);
  endtask

  task send_rx();
    logic [15:0] w;
    w = rnd();
    exp_rx.push_back(w);
    peer.send_word(w);
  endtask

  // drains both directions, then lets the crossing settle
  task wait_idle(input int lim);
    for (i = 0; i < lim && (exp_tx.size() > 0 || peer.pq.size() > 0); i++) @(negedge clk);
    tmo(i, lim);
    repeat (40) @(negedge clk);
  endtask

  // result side: oldest note off the matching queue
  always @(posedge clk) rd_pend <= rx_rd && !rx_empty;
  always @(negedge clk) begin
    if (got_v === 1'b1) begin
      ew = exp_tx.pop_front();
      `CHK("tx_word", ew, got_w)
    end
    if (rd_pend === 1'b1) begin
      ew = exp_rx.pop_front();
      `CHK("rx_word", ew, rx_data)
    end
  end

  initial begin
    tx_wr = '0;
    rx_rd = 1'b0;
    stall = 1'b0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 100 && tx_full !== 1'b0; i++) @(negedge clk);
    tmo(i, 100);
    `CHK("far_side_reset", 1'b0, far_rst_out)
    // back-to-back writes stream out as paired parcels
    repeat (6) wr_word(rnd());
    tx_wr.wr = 1'b0;
    wait_idle(500);
    // stalled peer: fill until refused, one dropped write, then drain
    stall = 1'b1;
    repeat (6) @(negedge clk);
    for (int k = 0; k < 40 && tx_full !== 1'b1; k++) wr_word(rnd());
    tx_wr.data = rnd();
    repeat (2) @(negedge clk);
    `CHK("tx_full", 1'b1, tx_full)
    tx_wr.wr = 1'b0;
    repeat (20) @(negedge clk);
    stall = 1'b0;
    wait_idle(2000);
    // only idle parcels with toggling data so far on the input
    `CHK("rx_empty", 1'b1, rx_empty)
    `CHK("rx_near_full", 1'b0, rx_nf)
    // fill the receive side up to the near-full boundary
    repeat (31) send_rx();
    wait_idle(3000);
    `CHK("rx_near_full", 1'b0, rx_nf)
    send_rx();
    wait_idle(300);
    `CHK("rx_near_full", 1'b1, rx_nf)
    repeat (32) rd_word();
    rx_rd = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("rx_empty", 1'b1, rx_empty)
    `CHK("rx_near_full", 1'b0, rx_nf)
    complete_run();
  end
endmodule // dcl_link_bench
